// ---- shared/pss_pkg.sv ----
// Package: constants and types for the synthesizer digital core
package pss_pkg;
	localparam int REF_WORD_BITS  = 16;
	localparam int PROG_WORD_BITS = 19;
	localparam int REF_LATCH_BITS = 15;
	localparam int PROG_LATCH_BITS = 18;
	localparam int REF_DIV_BITS   = 14;
	localparam int MAIN_BITS      = 11;
	localparam int SWALLOW_BITS   = 7;
	localparam int SHIFT_BITS     = 19;
	localparam int BASE_RATIO_LO  = 64;
	localparam int BASE_RATIO_HI  = 128;
	localparam int POS_RATIO_SEL  = 14;
	localparam int POS_MAIN_LSB   = 7;
	localparam int POS_SWALLOW_LSB = 0;
	localparam logic [14:0] REF_LATCH_RST  = 15'h0000;
	localparam logic [17:0] PROG_LATCH_RST = 18'h00000;

	typedef struct packed {
		logic        prescaler_ratio_select;
		logic [13:0] reference_division_number;
	} pss_ref_latch_t;

	typedef struct packed {
		logic [10:0] main_count;
		logic [6:0]  swallow_count;
	} pss_prog_latch_t;

	typedef struct packed {
		logic drive;
		logic level;
	} pss_pump_t;

	typedef enum logic [1:0] {
		PD_IDLE = 2'b00,
		PD_UP   = 2'b01,
		PD_DOWN = 2'b10
	} pss_pd_state_t;
endpackage

// ---- rtl/pss_divider.sv ----
// Module: loadable divide-by-N counter giving one-cycle output pulses
`timescale 1ns/1ps
module pss_divider
	import pss_pkg::*;
#(
	parameter int WIDTH = 18
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	// Count control
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] modulus,
	// Output
	output logic                  pulse
);
	if (WIDTH < 2) begin : g_width_check
		$error("WIDTH too small");
	end

	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	logic             pulse_reg;
	logic             pulse_next;

	always_comb begin
		cnt_next   = cnt_reg;
		pulse_next = 1'b0;
		if (!run) begin
			cnt_next = '0;
		end else if (tick) begin
			if (cnt_reg + WIDTH'(1) >= modulus) begin
				cnt_next   = '0;
				pulse_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= '0;
			pulse_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg   <= cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse = pulse_reg;
endmodule

// ---- rtl/pss_core.sv ----
// Module: serial-loaded synthesizer divider and phase comparator core
`timescale 1ns/1ps

module pss_core
	import pss_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Serial load port
	input  wire logic serial_shift_input_edge,
	input  wire logic serial_data,
	input  wire logic load_strobe,
	// Mode pins
	input  wire logic power_down_n,
	input  wire logic polarity_select,
	// Frequency inputs
	input  wire logic ref_oscillator_in,
	input  wire logic vco_in,
	// Charge pumps, output enable low while driving
	output logic      main_pump_out,
	output logic      main_pump_oe_n,
	output logic      aux_pump_out,
	output logic      aux_pump_oe_n,
	// Phase outputs and monitor
	output logic      ref_phase_out,
	output logic      prog_phase_out,
	output logic      monitor_out
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [3:0] edge_reg;
	logic       pdn_s;
	logic       pol_s;
	logic       sck_s;
	logic       sdat_s;
	logic       lat_s;
	logic       osc_s;
	logic       vco_s;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (clk_en) begin
			sync1_reg <= {serial_shift_input_edge, serial_data, load_strobe,
				ref_oscillator_in, vco_in, power_down_n, polarity_select};
			sync2_reg <= sync1_reg;
		end
	end

	assign {sck_s, sdat_s, lat_s, osc_s, vco_s, pdn_s, pol_s} = sync2_reg;

	logic active;
	assign active = pdn_s;

	////////////////////////////////////////////////////////////////////////
	// Shift register and latches
	logic [SHIFT_BITS-1:0] shift_reg;
	logic [SHIFT_BITS-1:0] shift_next;
	pss_ref_latch_t        ref_latch_reg;
	pss_ref_latch_t        ref_latch_next;
	pss_prog_latch_t       prog_latch_reg;
	pss_prog_latch_t       prog_latch_next;
	logic                  sck_rise;
	logic                  osc_rise;
	logic                  vco_rise;
	logic                  lat_rise;

	assign sck_rise = sck_s & ~edge_reg[3];
	assign lat_rise = lat_s & ~edge_reg[2];
	assign osc_rise = osc_s & ~edge_reg[1];
	assign vco_rise = vco_s & ~edge_reg[0];

	always_comb begin
		shift_next      = shift_reg;
		ref_latch_next  = ref_latch_reg;
		prog_latch_next = prog_latch_reg;
		if (active) begin
			if (sck_rise) begin
				shift_next = {shift_reg[SHIFT_BITS-2:0], sdat_s};
			end
			if (lat_rise) begin
				if (shift_reg[0]) begin
					// Ratio bit then divisor MSB first
					ref_latch_next = pss_ref_latch_t'(
						shift_reg[REF_WORD_BITS-1:1]);
				end else begin
					// Main then swallow
					prog_latch_next = pss_prog_latch_t'(
						shift_reg[PROG_WORD_BITS-1:1]);
				end
			end
		end
	end

	// Latches are never cleared by power-save
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg      <= '0;
			edge_reg       <= '0;
			ref_latch_reg  <= pss_ref_latch_t'(REF_LATCH_RST);
			prog_latch_reg <= pss_prog_latch_t'(PROG_LATCH_RST);
		end else if (clk_en) begin
			shift_reg      <= shift_next;
			edge_reg       <= {sck_s, lat_s, osc_s, vco_s};
			ref_latch_reg  <= ref_latch_next;
			prog_latch_reg <= prog_latch_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference divider
	logic ref_pulse;

	pss_divider #(
		.WIDTH(REF_DIV_BITS)
	) u_ref_div (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.run     (active),
		.tick    (osc_rise),
		.modulus (ref_latch_reg.reference_division_number),
		.pulse   (ref_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Pulse-swallow programmable divider
	logic [7:0]  pre_cnt_reg;
	logic [7:0]  pre_cnt_next;
	logic [10:0] main_cnt_reg;
	logic [10:0] main_cnt_next;
	logic [6:0]  sw_cnt_reg;
	logic [6:0]  sw_cnt_next;
	logic        prog_pulse_reg;
	logic        prog_pulse_next;
	logic [7:0]  pre_mod;

	function automatic logic [7:0] base_ratio(input logic sel);
		return sel ? 8'(BASE_RATIO_LO) : 8'(BASE_RATIO_HI);
	endfunction

	// Base plus one while swallowing
	assign pre_mod = base_ratio(ref_latch_reg.prescaler_ratio_select)
		- ((sw_cnt_reg < prog_latch_reg.swallow_count) ? 8'h00 : 8'h01);

	always_comb begin
		pre_cnt_next    = pre_cnt_reg;
		main_cnt_next   = main_cnt_reg;
		sw_cnt_next     = sw_cnt_reg;
		prog_pulse_next = 1'b0;
		if (!active) begin
			pre_cnt_next  = '0;
			main_cnt_next = '0;
			sw_cnt_next   = '0;
		end else if (vco_rise) begin
			if (pre_cnt_reg >= pre_mod) begin
				pre_cnt_next = '0;
				if (sw_cnt_reg < prog_latch_reg.swallow_count) begin
					sw_cnt_next = sw_cnt_reg + 7'h01;
				end
				if (main_cnt_reg + 11'h001 >= prog_latch_reg.main_count) begin
					main_cnt_next   = '0;
					sw_cnt_next     = '0;
					prog_pulse_next = 1'b1;
				end else begin
					main_cnt_next = main_cnt_reg + 11'h001;
				end
			end else begin
				pre_cnt_next = pre_cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_reg    <= '0;
			main_cnt_reg   <= '0;
			sw_cnt_reg     <= '0;
			prog_pulse_reg <= 1'b0;
		end else if (clk_en) begin
			pre_cnt_reg    <= pre_cnt_next;
			main_cnt_reg   <= main_cnt_next;
			sw_cnt_reg     <= sw_cnt_next;
			prog_pulse_reg <= prog_pulse_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase comparator and outputs
	pss_pd_state_t pd_reg;
	pss_pd_state_t pd_next;
	logic          ref_div_reg;
	logic          ref_div_next;
	logic          prog_div_reg;
	logic          prog_div_next;
	pss_pump_t     pump_next;
	pss_pump_t     pump_reg;
	logic [2:0]    out_next;
	logic [2:0]    out_reg;
	logic          aux_en_reg;

	always_comb begin
		pd_next       = pd_reg;
		ref_div_next  = ref_div_reg ^ ref_pulse;
		prog_div_next = prog_div_reg ^ prog_pulse_reg;
		if (!active) begin
			pd_next = PD_IDLE;
		end else begin
			unique case (pd_reg)
				PD_IDLE: begin
					if (ref_pulse && !prog_pulse_reg) pd_next = PD_UP;
					else if (prog_pulse_reg && !ref_pulse) pd_next = PD_DOWN;
				end
				PD_UP: if (prog_pulse_reg) pd_next = PD_IDLE;
				PD_DOWN: if (ref_pulse) pd_next = PD_IDLE;
				default: pd_next = PD_IDLE;
			endcase
		end
		// Pump level and phase outputs
		pump_next.drive = active && (pd_next != PD_IDLE);
		pump_next.level = (pd_next == PD_UP) ~^ pol_s;
		if (pd_next == PD_IDLE) begin
			out_next[2:1] = 2'b01;
		end else begin
			out_next[2:1] = {2{~pump_next.level}};
		end
		// Monitor select
		out_next[0] = pol_s ? ref_div_next : prog_div_next;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_reg       <= PD_IDLE;
			ref_div_reg  <= 1'b0;
			prog_div_reg <= 1'b0;
			pump_reg     <= '0;
			out_reg      <= 3'h2;
			aux_en_reg   <= 1'b0;
		end else if (clk_en) begin
			pd_reg       <= pd_next;
			ref_div_reg  <= ref_div_next;
			prog_div_reg <= prog_div_next;
			pump_reg     <= pump_next;
			out_reg      <= out_next;
			aux_en_reg   <= lat_s;
		end
	end

	assign main_pump_out  = pump_reg.level;
	assign main_pump_oe_n = ~pump_reg.drive;
	assign aux_pump_out   = pump_reg.level;
	assign aux_pump_oe_n  = ~(pump_reg.drive & aux_en_reg);
	assign ref_phase_out  = out_reg[2];
	assign prog_phase_out = out_reg[1];
	assign monitor_out    = out_reg[0];
endmodule

// ---- sim/pss_core_chk.sv ----
// Checker: port-level assertions for the synthesizer core
`timescale 1ns/1ps
module pss_core_chk
	import pss_pkg::*;
(
	// Clock, reset, mode pins and load strobe
	input wire logic core_clk, rst_n, power_down_n,
	input wire logic polarity_select, load_strobe,
	// Pumps, phase outputs and monitor
	input wire logic main_pump_out, main_pump_oe_n,
	input wire logic aux_pump_out, aux_pump_oe_n,
	input wire logic ref_phase_out, prog_phase_out, monitor_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	sequence s_save;
		(!power_down_n)[*4];
	endsequence
	sequence s_pol(b);
		polarity_select == b && $past(polarity_select) == b;
	endsequence
	sequence s_drive;
		!main_pump_oe_n;
	endsequence
	AST_SAVE_FLOAT: assert property (s_save |->
		main_pump_oe_n && aux_pump_oe_n) else $error("pump on in save");
	AST_SAVE_MON: assert property (s_save |=>
		$stable(monitor_out)) else $error("monitor moved in save");
	AST_AUX_OFF: assert property ((!load_strobe)[*4] |->
		aux_pump_oe_n) else $error("aux pump on, strobe low");
	AST_AUX_ON: assert property (load_strobe[*4] ##0 s_drive |->
		!aux_pump_oe_n && aux_pump_out == main_pump_out)
		else $error("aux pump not following");
	AST_IDLE: assert property (power_down_n && main_pump_oe_n |->
		!ref_phase_out && prog_phase_out) else $error("idle phases");
	AST_POL_HI: assert property (s_pol(1'b1) ##0 s_drive |->
		ref_phase_out == prog_phase_out && main_pump_out != ref_phase_out)
		else $error("polarity high table");
	AST_POL_LO: assert property (s_pol(1'b0) ##0 s_drive |->
		ref_phase_out == prog_phase_out && main_pump_out != ref_phase_out)
		else $error("polarity low table");
	AST_PUMP_HOLD: assert property (s_drive ##1 (s_drive
		&& $stable(polarity_select)
		&& polarity_select == $past(polarity_select, 2)
		&& polarity_select == $past(polarity_select, 4)) |->
		$stable(main_pump_out)) else $error("pump level flipped");
endmodule

bind pss_core pss_core_chk u_chk (.core_clk, .rst_n, .power_down_n,
	.polarity_select, .load_strobe, .main_pump_out, .main_pump_oe_n,
	.aux_pump_out, .aux_pump_oe_n, .ref_phase_out, .prog_phase_out,
	.monitor_out);

// ---- sim/pss_ctrl_model.sv ----
// Model: external controller on the three-wire serial port
`timescale 1ns/1ps
module pss_ctrl_model (
	// Clock
	input  wire logic core_clk,
	// Serial load port
	output logic      serial_shift_input_edge,
	output logic      serial_data,
	output logic      load_strobe
);
	initial begin
		serial_shift_input_edge = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// MSB first, flag last, then strobe
	task automatic send(input logic [18:0] w, input int n);
		load_strobe <= 1'b0;
		wait_clk(13);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data <= w[i];
			wait_clk(4);
			serial_shift_input_edge <= 1'b1;
			wait_clk(4);
			serial_shift_input_edge <= 1'b0;
		end
		wait_clk(4);
		serial_data <= ~w[0];
		load_strobe <= 1'b1;
		wait_clk(13);
	endtask
endmodule

// ---- sim/tb_pss_core.sv ----
// Testbench: serial loads, division checks, power-save
`timescale 1ns/1ps
module tb_pss_core
	import pss_pkg::*;
;
	logic core_clk, rst_n, clk_en, power_down_n, polarity_select;
	logic ref_oscillator_in, vco_in;
	logic serial_shift_input_edge, serial_data, load_strobe;
	logic main_pump_out, main_pump_oe_n, aux_pump_out, aux_pump_oe_n;
	logic ref_phase_out, prog_phase_out, monitor_out;
	int   mismatches = 0;
	int   n_checks = 0;
	int   edges_n = 0;
	int   div3 = 0;
	pss_core u_dut (.core_clk, .rst_n, .clk_en, .serial_shift_input_edge,
		.serial_data, .load_strobe, .power_down_n, .polarity_select,
		.ref_oscillator_in, .vco_in, .main_pump_out, .main_pump_oe_n,
		.aux_pump_out, .aux_pump_oe_n, .ref_phase_out, .prog_phase_out,
		.monitor_out);
	pss_ctrl_model u_ctl (.core_clk, .serial_shift_input_edge,
		.serial_data, .load_strobe);
	////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Both frequency inputs: one rising edge per six cycles
	always @(posedge core_clk) begin
		div3 <= (div3 == 2) ? 0 : div3 + 1;
		if (div3 == 2) begin
			ref_oscillator_in <= ~ref_oscillator_in;
			vco_in <= ~vco_in;
			if (!vco_in)
				edges_n <= edges_n + 1;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic wait_flip;
		logic m;
		int   k;
		@(negedge core_clk);
		m = monitor_out;
		k = 0;
		while (monitor_out === m && k < 4000) begin
			@(negedge core_clk);
			k++;
		end
		if (k == 4000)
			check(0, 1);
	endtask
	// Input edges between two monitor flips
	task automatic measure(input int exp);
		int t0;
		wait_flip();
		wait_flip();
		t0 = edges_n;
		wait_flip();
		check(edges_n - t0, exp);
		@(posedge core_clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		power_down_n = 1'b1;
		polarity_select = 1'b1;
		ref_oscillator_in = 1'b0;
		vco_in = 1'b0;
		repeat (12) @(posedge core_clk);
		check(main_pump_oe_n, 1'b1);
		check(ref_phase_out, 1'b0);
		check(prog_phase_out, 1'b1);
		rst_n <= 1'b1;
		u_ctl.send({3'h0, 1'b1, 14'h0005, 1'b1}, 16);
		u_ctl.send({11'h003, 7'h02, 1'b0}, 19);
		measure(5);
		polarity_select <= 1'b0;
		measure(194);
		$display("test init done");
		u_ctl.send({11'h004, 7'h01, 1'b0}, 19);
		measure(257);
		polarity_select <= 1'b1;
		measure(5);
		$display("test update done");
		power_down_n <= 1'b0;
		u_ctl.send({11'h005, 7'h00, 1'b0}, 19);
		check(main_pump_oe_n, 1'b1);
		check(aux_pump_oe_n, 1'b1);
		power_down_n <= 1'b1;
		polarity_select <= 1'b0;
		measure(257);
		$display("test save done");
		u_ctl.send({3'h0, 1'b0, 14'h0005, 1'b1}, 16);
		measure(513);
		polarity_select <= 1'b1;
		measure(5);
		$display("test ratio done");
		complete_run();
	end
endmodule
